// ==== bench/cgd_mem_model.sv ====
// cgd_mem_model: low-memory words that the auto-index sequencer reads
// assumes one read at a time, answered after lat idle clocks
`timescale 1ns/10ps
`default_nettype none
module cgd_mem_model
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic idx_rd,
	input wire logic [4:0] idx_addr,
	input wire logic [3:0] lat,
	output logic idx_rvalid,
	output logic [15:0] idx_rdata
);
	logic [15:0] mem [0:31];
	logic [3:0] wait_r;
	////////////////////////////////////////////////////////////////
	// one-cycle answer; data toggles when not valid so a stale word never matches
	always_ff @(posedge aclk)
	begin
		idx_rvalid <= 1'b0;
		idx_rdata <= ~idx_rdata;
		if (!aresetn)
		begin
			wait_r <= 4'h0;
			idx_rdata <= 16'h5a5a;
		end
		else if (idx_rd && !idx_rvalid)
		begin
			wait_r <= wait_r + 4'h1;
			if (wait_r == lat)
			begin
				idx_rvalid <= 1'b1;
				idx_rdata <= mem[idx_addr];
				wait_r <= 4'h0;
			end
		end
	end
endmodule
`default_nettype wire

// ==== bench/cgd_top_tb.sv ====
// cgd_top_tb: instruction sequences and register accesses with expected results
// assumes the memory model on the index port and a 40 MHz clock
`timescale 1ns/10ps
`default_nettype none
module cgd_top_tb
	import cgd_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0, ins_valid = 1'b0, c, ins_ready, idx_rd, idx_rvalid, done;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf, lat = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [4:0] idx_addr;
	logic [15:0] idx_rdata;
	logic [9:0] mk [2] = '{10'h0d7, 10'h229};
	cgd_ins_t ins = '0;
	cgd_regs_t regs = '0, rg;
	cgd_regs_t rs [2];
	cgd_res_t res;
	cgd_io_t io_cmd;
	int n_errors = 0, comparisons = 0, nret = 0;
	cgd_top dut(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ins_valid, .ins_ready, .ins,
		.regs, .idx_rd, .idx_addr, .idx_rvalid, .idx_rdata, .done, .res, .io_cmd);
	cgd_mem_model mdl(.aclk, .aresetn, .idx_rd, .idx_addr, .lat, .idx_rvalid, .idx_rdata);
	////////////////////////////////////////////////////////////////
	// free-running clock, 25 ns period
	always #12.5 aclk = ~aclk;
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic end_sim();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// address and data offered together, each released at its own handshake
	task automatic axw(input logic [31:0] a, input logic [31:0] v);
		logic ta = 1'b0;
		logic tw = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ta && tw))
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			ta = ta | s_axi_awready;
			tw = tw | s_axi_wready;
		end
		while (!s_axi_bvalid) @(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [31:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// clocks are counted from the take, or from the index answer for auto-index
	task automatic run(input logic [15:0] iw, input int nc, input logic [14:0] np);
		int n = 0;
		@(posedge aclk);
		ins_valid <= 1'b1;
		ins <= '{iw, 16'h0200, 15'h0100};
		regs <= rg;
		do @(posedge aclk); while (!ins_ready);
		ins_valid <= 1'b0;
		do
		begin
			@(posedge aclk);
			n = idx_rvalid ? 0 : n + 1;
			#1;
		end
		while (!done && n < 99);
		nret++;
		chk("cycles", 4 * nc, n);
		chk("next_p", np, res.next_p);
	endtask
	////////////////////////////////////////////////////////////////
	// hang guard, well beyond the expected run length
	initial
	begin
		#500000;
		n_errors++;
		end_sim();
	end
	// main sequence
	initial
	begin
		rs[0] = '{16'h0000, 16'h0005, 16'h0000, 1'b1, 3'h1};
		rs[1] = '{16'h8000, 16'h0000, 16'h0003, 1'b0, 3'h4};
		mdl.mem[3] = 16'hffff;
		mdl.mem[4] = 16'h0005;
		mdl.mem[5] = 16'h0002;
		mdl.mem[6] = 16'h0001;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		axr(32'h0);
		chk("ctrl", 32'h1, d);
		axr(32'h10);
		chk("decerr", 2'h3, r);
		for (int s = 0; s < 2; s++)
			for (int m = 1; m < 4; m++)
				for (int i = 0; i < 10; i++)
				begin
					c = mk[s][i];
					rg = rs[s];
					run({4'h0, 3'(m), i ? 9'h001 << (i - 1) : 9'h000}, (m == 2 && c && i > 0) ? 3 : 2,
						(!c || m == 3) ? 15'h0102 : 15'h0200 + 15'(m == 2));
					if (m == 2) chk("mark_we", c, res.mem_we);
					if (m == 2 && c) chk("ret_addr", 16'h0102, res.mem_wdata);
					if (m == 3) chk("exec_go", c, res.exec_go);
				end
		rg = rs[0];
		run(16'h801f, 1, 15'h0101);
		run(16'h8332, 2, 15'h0101);
		run(16'h841f, 3, 15'h0102);
		run(16'h845f, 2, 15'h0101);
		run(16'h849f, 2, 15'h0101);
		run(16'h855f, 2, 15'h0101);
		run(16'h859f, 2, 15'h0101);
		run(16'h861f, 2, 15'h0102);
		run(16'h865f, 2, 15'h0101);
		chk("io_cmd", 12'he5f, io_cmd);
		axw(32'h0, 32'hd);
		run(16'h0c70, 10, 15'h0102);
		chk("func", 6'h0e, res.func);
		run(16'h0c78, 14, 15'h0102);
		run(16'h0c08, 2, 15'h0102);
		run(16'h0e09, 2, 15'h0102);
		run(16'h0e23, 4, 15'h0200);
		chk("sum", 16'h0000, res.mem_wdata);
		run(16'h0e64, 4, 15'h0200);
		chk("sum", 16'h0006, res.mem_wdata);
		@(posedge aclk) lat <= 4'h5;
		run(16'h0ea5, 3, 15'h0102);
		chk("sum", 16'h0001, res.mem_wdata);
		run(16'h0ee6, 3, 15'h0102);
		chk("index_addr", 15'h0006, res.mem_addr);
		axr(32'h8);
		chk("count", nret, d);
		run(16'h0c40, 1, 15'h0101);
		axr(32'h4);
		chk("illegal", 1'b1, d[0]);
		axw(32'h4, 32'h1);
		axr(32'h4);
		chk("cleared", 1'b0, d[0]);
		axw(32'h0, 32'h3);
		run(16'h0c08, 3, 15'h0102);
		axr(32'hc);
		chk("last_iw", 32'h0c08, d);
		axr(32'h4);
		chk("stat_grp", 32'h70, d);
		axw(32'h0, 32'h0);
		repeat (3) @(posedge aclk);
		chk("ready_off", 1'b0, ins_ready);
		end_sim();
	end
endmodule
`default_nettype wire

// ==== verilog/cgd_axil.sv ====
// axi4-lite slave for the decoder's four register words
// assumes the top supplies read data combinationally from rd_addr
`timescale 1ns/10ps
`default_nettype none
module cgd_axil
	import cgd_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_en,
	output logic [3:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	output logic [3:0] rd_addr,
	input wire logic [31:0] rd_data
);
	logic [31:0] awa_r, awa_nxt, wd_r, wd_nxt;
	logic [3:0] ws_r, ws_nxt;
	logic awg_r, awg_nxt, wg_r, wg_nxt, awr_r, awr_nxt, wr_r, wr_nxt;
	logic bv_r, bv_nxt, we_r, we_nxt, arr_r, arr_nxt, rv_r, rv_nxt;
	logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic fire, ar_hit;

	// address and data are held separately, so either may arrive first
	always_comb
	begin
		awg_nxt = awg_r | (s_axi_awvalid & awr_r);
		awa_nxt = (s_axi_awvalid & awr_r) ? s_axi_awaddr : awa_r;
		wg_nxt = wg_r | (s_axi_wvalid & wr_r);
		wd_nxt = (s_axi_wvalid & wr_r) ? s_axi_wdata : wd_r;
		ws_nxt = (s_axi_wvalid & wr_r) ? s_axi_wstrb : ws_r;
		bv_nxt = bv_r & ~s_axi_bready;
		br_nxt = br_r;
		fire = awg_r & wg_r & ~bv_r;
		we_nxt = fire & (awa_r[31:4] == 28'h0000000);
		if (fire)
		begin
			awg_nxt = 1'b0;
			wg_nxt = 1'b0;
			bv_nxt = 1'b1;
			br_nxt = (awa_r[31:4] == 28'h0000000) ? CGD_RESP_OK : CGD_RESP_DEC;
		end
		awr_nxt = ~awg_nxt;
		wr_nxt = ~wg_nxt;
	end

	// reads answer one cycle after the address is taken
	always_comb
	begin
		ar_hit = s_axi_araddr[31:4] == 28'h0000000;
		arr_nxt = arr_r;
		rv_nxt = rv_r;
		rd_nxt = rd_r;
		rr_nxt = rr_r;
		if (s_axi_arvalid & arr_r)
		begin
			arr_nxt = 1'b0;
			rv_nxt = 1'b1;
			rd_nxt = ar_hit ? rd_data : 32'h00000000;
			rr_nxt = ar_hit ? CGD_RESP_OK : CGD_RESP_DEC;
		end
		else if (rv_r & s_axi_rready)
		begin
			arr_nxt = 1'b1;
			rv_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awa_r <= 32'h00000000;
			wd_r <= 32'h00000000;
			ws_r <= 4'h0;
			awg_r <= 1'b0;
			wg_r <= 1'b0;
			awr_r <= 1'b1;
			wr_r <= 1'b1;
			bv_r <= 1'b0;
			br_r <= CGD_RESP_OK;
			we_r <= 1'b0;
			arr_r <= 1'b1;
			rv_r <= 1'b0;
			rd_r <= 32'h00000000;
			rr_r <= CGD_RESP_OK;
		end
		else
		begin
			awa_r <= awa_nxt;
			wd_r <= wd_nxt;
			ws_r <= ws_nxt;
			awg_r <= awg_nxt;
			wg_r <= wg_nxt;
			awr_r <= awr_nxt;
			wr_r <= wr_nxt;
			bv_r <= bv_nxt;
			br_r <= br_nxt;
			we_r <= we_nxt;
			arr_r <= arr_nxt;
			rv_r <= rv_nxt;
			rd_r <= rd_nxt;
			rr_r <= rr_nxt;
		end
	end

	assign s_axi_awready = awr_r;
	assign s_axi_wready = wr_r;
	assign s_axi_bvalid = bv_r;
	assign s_axi_bresp = br_r;
	assign s_axi_arready = arr_r;
	assign s_axi_rvalid = rv_r;
	assign s_axi_rdata = rd_r;
	assign s_axi_rresp = rr_r;
	assign wr_en = we_r; // write strobe rises in the same cycle as the response
	assign wr_addr = awa_r[3:0];
	assign wr_data = wd_r;
	assign wr_strb = ws_r;
	assign rd_addr = s_axi_araddr[3:0];
endmodule
`default_nettype wire

// ==== verilog/cgd_cond.sv ====
// condition tester: AND of every test picked by a set a-field bit
// assumes register values are settled in the cycle they are sampled
`timescale 1ns/10ps
`default_nettype none
module cgd_cond
	import cgd_pkg::*;
(
	input wire logic [8:0] sel,
	input wire cgd_regs_t regs,
	output logic ok
);
	logic [8:0] test;

	// one test per a-field bit; an empty field is always true
	always_comb
	begin
		test[0] = regs.overflow_flag;
		test[1] = !regs.acc_a[15];
		test[2] = regs.acc_a[15];
		test[3] = regs.acc_a == 16'h0000;
		test[4] = regs.acc_b == 16'h0000;
		test[5] = regs.index_x == 16'h0000;
		test[8:6] = regs.sense;
		ok = &(test | ~sel);
	end
endmodule
`default_nettype wire

// ==== verilog/cgd_pkg.sv ====
// control group decoder: shared constants, types and field layouts
// assumes a 16-bit word, 15-bit addresses and one clock domain
package cgd_pkg;
	// opcode and mode fields
	localparam logic [3:0] CGD_OP_CTRL = 4'h0;
	localparam logic [3:0] CGD_OP_IO = 4'h8;
	localparam logic [2:0] CGD_M_JUMP = 3'h1;
	localparam logic [2:0] CGD_M_MARK = 3'h2;
	localparam logic [2:0] CGD_M_EXEC = 3'h3;
	localparam logic [2:0] CGD_M_IMM = 3'h6;
	localparam logic [2:0] CGD_M_AUX = 3'h7;
	localparam int CGD_AUX_BIT = 5;
	localparam logic [1:0] CGD_AUTO_INC_Z = 2'h0;
	// byte group a-field codes
	localparam logic [8:0] CGD_BYTE_LD = 9'h000;
	localparam logic [8:0] CGD_BYTE_ST = 9'h009;
	localparam logic [8:0] CGD_BYTE_LDC = 9'h00c;
	localparam logic [8:0] CGD_BYTE_STC = 9'h015;
	// function digits, a field bits 8..3
	localparam logic [5:0] CGD_F_BUMP = 6'h04;
	localparam logic [5:0] CGD_F_HOLE = 6'h08;
	localparam logic [5:0] CGD_F_MUL = 6'h0e;
	localparam logic [5:0] CGD_F_DIV = 6'h0f;
	localparam logic [5:0] CGD_F_EXT_LAST = 6'h05;
	// io modes and sub-codes
	localparam logic [1:0] CGD_IO_EXC = 2'h0;
	localparam logic [1:0] CGD_IO_SEN = 2'h1;
	localparam logic [1:0] CGD_IO_IN = 2'h2;
	localparam logic [1:0] CGD_IO_OUT = 2'h3;
	localparam logic [2:0] CGD_SUB_MEM = 3'h0;
	localparam logic [2:0] CGD_SUB_B = 3'h2;
	localparam logic [2:0] CGD_SUB_CLR_A = 3'h5;
	localparam logic [2:0] CGD_SUB_CLR_B = 3'h6;
	// timing in memory cycles, and clocks per memory cycle
	localparam logic [3:0] CGD_CYC_1 = 4'h1;
	localparam logic [3:0] CGD_CYC_2 = 4'h2;
	localparam logic [3:0] CGD_CYC_3 = 4'h3;
	localparam logic [3:0] CGD_CYC_4 = 4'h4;
	localparam logic [3:0] CGD_CYC_MUL = 4'ha;
	localparam logic [3:0] CGD_CYC_DIV = 4'he;
	localparam logic [3:0] CGD_CLKS_PER_CYC = 4'h4;
	// register map and fields
	localparam logic [3:0] CGD_REG_CTRL = 4'h0;
	localparam logic [3:0] CGD_REG_STAT = 4'h4;
	localparam logic [3:0] CGD_REG_COUNT = 4'h8;
	localparam logic [3:0] CGD_REG_LASTIW = 4'hc;
	localparam int CGD_CTRL_EN = 0;
	localparam int CGD_CTRL_EXT = 1;
	localparam int CGD_CTRL_BYTE = 2;
	localparam int CGD_CTRL_MULDIV = 3;
	localparam logic [3:0] CGD_CTRL_RST = 4'h1;
	localparam int CGD_STAT_ILL = 0;
	localparam int CGD_STAT_BUSY = 1;
	localparam int CGD_STAT_GRP = 4;
	localparam logic [1:0] CGD_RESP_OK = 2'h0;
	localparam logic [1:0] CGD_RESP_DEC = 2'h3;

	typedef enum logic [1:0] {S_IDLE, S_IDX, S_COUNT} cgd_state_t;
	typedef enum logic [3:0] {CGD_G_NONE, CGD_G_JUMP, CGD_G_MARK, CGD_G_EXEC, CGD_G_AUTO,
		CGD_G_BYTE, CGD_G_IMM, CGD_G_EXT, CGD_G_IO} cgd_grp_t;
	// datapath state sampled with each instruction; sense[0] is switch 1
	typedef struct packed {
		logic [15:0] acc_a;
		logic [15:0] acc_b;
		logic [15:0] index_x;
		logic overflow_flag;
		logic [2:0] sense;
	} cgd_regs_t;
	typedef struct packed {
		logic [15:0] iw;
		logic [15:0] aw;
		logic [14:0] p;
	} cgd_ins_t;
	typedef struct packed {
		cgd_grp_t grp;
		logic [14:0] next_p;
		logic exec_go;
		logic mem_we;
		logic [14:0] mem_addr;
		logic [15:0] mem_wdata;
		logic [5:0] func;
	} cgd_res_t;
	typedef struct packed {
		logic valid;
		logic [1:0] kind;
		logic [2:0] sub;
		logic [5:0] dev;
	} cgd_io_t;
endpackage

// ==== verilog/cgd_top.sv ====
// control group and io instruction decoder with its sequencer
// assumes the fetch path offers an instruction with its address word,
// the datapath values in the same cycle, and answers index reads later
`timescale 1ns/10ps
`default_nettype none
module cgd_top
	import cgd_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ins_valid,
	output logic ins_ready,
	input wire cgd_ins_t ins,
	input wire cgd_regs_t regs,
	output logic idx_rd,
	output logic [4:0] idx_addr,
	input wire logic idx_rvalid,
	input wire logic [15:0] idx_rdata,
	output logic done,
	output var cgd_res_t res,
	output var cgd_io_t io_cmd
);
	logic [8:0] a_fld;
	logic [2:0] m_fld;
	logic [5:0] f_fld;
	logic [14:0] tgt, p1, p2;
	logic cond_ok, wr_en, take, ill_set, d_auto, d_ill, aux_jmp;
	logic [3:0] wr_addr, wr_strb, rd_addr, d_cyc;
	logic [31:0] wr_data, rd_data;
	logic [15:0] aux_val;
	cgd_res_t d_res, res_r, res_nxt;
	cgd_io_t d_io, io_r, io_nxt;
	cgd_ins_t ins_r, ins_nxt;
	cgd_state_t st_r, st_nxt;
	logic [3:0] ctrl_r, ctrl_nxt, tot_r, tot_nxt, left_r, left_nxt, clk_r, clk_nxt;
	logic ill_r, ill_nxt, jmp_r, jmp_nxt, rdy_r, rdy_nxt, done_r, done_nxt;
	logic idx_rd_r, idx_rd_nxt;
	logic [1:0] kind_r, kind_nxt;
	logic [4:0] idx_addr_r, idx_addr_nxt;
	logic [14:0] jadr_r, jadr_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [7:0] el_r;

	////////////////////////////////////////////////////////////////
	// register bus

	cgd_axil u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	// control bits, sticky illegal flag (a new set beats a clear), read mux
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		ill_nxt = ill_r;
		if (wr_en && wr_strb[0] && wr_addr == CGD_REG_CTRL)
			ctrl_nxt = wr_data[3:0];
		if (wr_en && wr_strb[0] && wr_addr == CGD_REG_STAT && wr_data[CGD_STAT_ILL])
			ill_nxt = 1'b0;
		if (ill_set)
			ill_nxt = 1'b1;
		rd_data = 32'h00000000;
		case (rd_addr)
			CGD_REG_CTRL: rd_data[3:0] = ctrl_r;
			CGD_REG_STAT:
			begin
				rd_data[CGD_STAT_ILL] = ill_r;
				rd_data[CGD_STAT_BUSY] = st_r != S_IDLE;
				rd_data[CGD_STAT_GRP +: 4] = res_r.grp;
			end
			CGD_REG_COUNT: rd_data[15:0] = cnt_r;
			CGD_REG_LASTIW: rd_data[15:0] = ins_r.iw;
			default: rd_data = 32'h00000000;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r <= CGD_CTRL_RST;
			ill_r <= 1'b0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			ill_r <= ill_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// decode

	assign a_fld = ins.iw[8:0];
	assign m_fld = ins.iw[11:9];
	assign f_fld = ins.iw[8:3];
	assign tgt = ins.aw[14:0];
	assign p1 = ins.p + 15'h0001;
	assign p2 = ins.p + 15'h0002;

	cgd_cond u_cond (
		.sel(a_fld),
		.regs(regs),
		.ok(cond_ok)
	);

	// classify the offered word; undecodable codes retire as a no-op in one cycle
	always_comb
	begin
		d_res = '0;
		d_io = '0;
		d_cyc = CGD_CYC_2;
		d_auto = 1'b0;
		d_ill = 1'b0;
		d_res.next_p = p2;
		d_res.mem_addr = tgt;
		d_res.func = f_fld;
		if (ins.iw[15:12] == CGD_OP_IO)
		begin
			d_res.grp = CGD_G_IO;
			d_io.valid = 1'b1;
			d_io.kind = m_fld[1:0];
			d_io.sub = a_fld[8:6];
			d_io.dev = a_fld[5:0];
			d_ill = m_fld[2];
			// only the memory forms carry an address word
			if (!(m_fld[1] && a_fld[8:6] == CGD_SUB_MEM))
				d_res.next_p = p1;
			unique case (m_fld[1:0])
				CGD_IO_EXC: d_cyc = CGD_CYC_1;
				CGD_IO_SEN: d_cyc = CGD_CYC_2;
				CGD_IO_IN:
				begin
					if (a_fld[8:6] == CGD_SUB_MEM)
						d_cyc = CGD_CYC_3;
					if (a_fld[8:6] > CGD_SUB_B && a_fld[8:6] != CGD_SUB_CLR_A && a_fld[8:6] != CGD_SUB_CLR_B)
						d_ill = 1'b1;
				end
				CGD_IO_OUT: d_ill = d_ill | (a_fld[8:6] > CGD_SUB_B);
			endcase
		end
		else if (ins.iw[15:12] == CGD_OP_CTRL)
		begin
			unique case (m_fld)
				CGD_M_JUMP:
				begin
					d_res.grp = CGD_G_JUMP;
					d_res.next_p = cond_ok ? tgt : p2;
				end
				CGD_M_MARK:
				begin
					d_res.grp = CGD_G_MARK;
					// return address goes to the target, execution resumes after it
					d_res.mem_we = cond_ok;
					d_res.mem_wdata = {1'b0, p2};
					d_res.next_p = cond_ok ? tgt + 15'h0001 : p2;
					d_cyc = (cond_ok && a_fld != 9'h000) ? CGD_CYC_3 : CGD_CYC_2;
				end
				CGD_M_EXEC:
				begin
					// the fetch path runs the single word at mem_addr, then p+2
					d_res.grp = CGD_G_EXEC;
					d_res.exec_go = cond_ok;
				end
				CGD_M_IMM:
					if (ctrl_r[CGD_CTRL_EXT])
					begin
						d_res.grp = CGD_G_EXT;
						d_cyc = CGD_CYC_3;
						d_ill = f_fld == 6'h00 || f_fld == CGD_F_BUMP || f_fld > CGD_F_EXT_LAST;
					end
					else
					begin
						d_res.grp = CGD_G_IMM;
						d_ill = f_fld == 6'h00 || f_fld == CGD_F_HOLE || f_fld > CGD_F_DIV;
						if (f_fld == CGD_F_MUL)
							d_cyc = CGD_CYC_MUL;
						if (f_fld == CGD_F_DIV)
							d_cyc = CGD_CYC_DIV;
						if (f_fld >= CGD_F_MUL && !ctrl_r[CGD_CTRL_MULDIV])
							d_ill = 1'b1;
					end
				CGD_M_AUX:
					if (a_fld[CGD_AUX_BIT])
					begin
						d_res.grp = CGD_G_AUTO;
						d_auto = 1'b1;
						d_res.mem_addr = {10'h000, a_fld[4:0]};
					end
					else
					begin
						d_res.grp = CGD_G_BYTE;
						d_res.func = a_fld[5:0];
						d_ill = !ctrl_r[CGD_CTRL_BYTE] || !(a_fld == CGD_BYTE_LD || a_fld == CGD_BYTE_ST
							|| a_fld == CGD_BYTE_LDC || a_fld == CGD_BYTE_STC);
					end
				default: d_ill = 1'b1;
			endcase
		end
		else
			d_ill = 1'b1;
		if (d_ill)
		begin
			d_res = '0;
			d_res.next_p = p1;
			d_io = '0;
			d_cyc = CGD_CYC_1;
			d_auto = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// sequencer

	// auto-index update: kind bit 1 picks decrement, bit 0 jump on nonzero
	assign aux_val = kind_r[1] ? idx_rdata - 16'h0001 : idx_rdata + 16'h0001;
	assign aux_jmp = kind_r[0] ? aux_val != 16'h0000 : aux_val == 16'h0000;

	// accept, fetch the index word if needed, then hold for the cycle count
	always_comb
	begin
		st_nxt = st_r;
		res_nxt = res_r;
		io_nxt = io_r;
		ins_nxt = ins_r;
		tot_nxt = tot_r;
		left_nxt = left_r;
		clk_nxt = clk_r;
		kind_nxt = kind_r;
		jmp_nxt = jmp_r;
		jadr_nxt = jadr_r;
		idx_rd_nxt = idx_rd_r;
		idx_addr_nxt = idx_addr_r;
		cnt_nxt = cnt_r;
		done_nxt = 1'b0;
		ill_set = 1'b0;
		take = st_r == S_IDLE && ins_valid && rdy_r;
		unique case (st_r)
			S_IDLE:
				if (take)
				begin
					ins_nxt = ins;
					res_nxt = d_res;
					io_nxt = d_io;
					tot_nxt = d_cyc;
					left_nxt = d_cyc;
					clk_nxt = 4'h0;
					kind_nxt = a_fld[7:6];
					jmp_nxt = 1'b0;
					jadr_nxt = tgt;
					idx_rd_nxt = d_auto;
					idx_addr_nxt = a_fld[4:0];
					ill_set = d_ill;
					st_nxt = d_auto ? S_IDX : S_COUNT;
				end
			S_IDX:
				if (idx_rvalid)
				begin
					idx_rd_nxt = 1'b0;
					res_nxt.mem_we = 1'b1;
					res_nxt.mem_wdata = aux_val;
					res_nxt.next_p = aux_jmp ? jadr_r : res_r.next_p;
					jmp_nxt = aux_jmp;
					tot_nxt = aux_jmp ? CGD_CYC_4 : CGD_CYC_3;
					left_nxt = aux_jmp ? CGD_CYC_4 : CGD_CYC_3;
					st_nxt = S_COUNT;
				end
			S_COUNT:
			begin
				clk_nxt = clk_r + 4'h1;
				if (clk_r == CGD_CLKS_PER_CYC - 4'h1)
				begin
					clk_nxt = 4'h0;
					left_nxt = left_r - 4'h1;
					if (left_r == CGD_CYC_1)
					begin
						st_nxt = S_IDLE;
						done_nxt = 1'b1;
						cnt_nxt = cnt_r + 16'h0001;
					end
				end
			end
			default: st_nxt = S_IDLE;
		endcase
		// ready stays low while disabled, so the fetch path stalls
		rdy_nxt = st_nxt == S_IDLE && ctrl_r[CGD_CTRL_EN];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r <= S_IDLE;
			res_r <= '0;
			io_r <= '0;
			ins_r <= '0;
			tot_r <= 4'h0;
			left_r <= 4'h0;
			clk_r <= 4'h0;
			kind_r <= 2'h0;
			jmp_r <= 1'b0;
			jadr_r <= 15'h0000;
			idx_rd_r <= 1'b0;
			idx_addr_r <= 5'h00;
			cnt_r <= 16'h0000;
			done_r <= 1'b0;
			rdy_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			res_r <= res_nxt;
			io_r <= io_nxt;
			ins_r <= ins_nxt;
			tot_r <= tot_nxt;
			left_r <= left_nxt;
			clk_r <= clk_nxt;
			kind_r <= kind_nxt;
			jmp_r <= jmp_nxt;
			jadr_r <= jadr_nxt;
			idx_rd_r <= idx_rd_nxt;
			idx_addr_r <= idx_addr_nxt;
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
			rdy_r <= rdy_nxt;
		end
	end

	assign ins_ready = rdy_r;
	assign idx_rd = idx_rd_r;
	assign idx_addr = idx_addr_r;
	assign done = done_r;
	assign res = res_r;
	assign io_cmd = io_r;

	////////////////////////////////////////////////////////////////
	// checks

	// clocks spent counting, read by the span check only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			el_r <= 8'h00;
		else
			el_r <= (st_r == S_COUNT) ? el_r + 8'h01 : 8'h00;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	cycle_span_a:
	assert property (done_r |-> el_r == 8'(tot_r) * 8'(CGD_CLKS_PER_CYC))
		else $error("instruction span differs from its cycle count");
	jump_cycles_a:
	assert property (done_r && res_r.grp == CGD_G_JUMP |-> tot_r == CGD_CYC_2)
		else $error("jump did not take two cycles");
	jump_always_a:
	assert property (done_r && res_r.grp == CGD_G_JUMP && ins_r.iw[8:0] == 9'h000 |-> res_r.next_p == ins_r.aw[14:0])
		else $error("unconditional jump not taken");
	mark_cycles_a:
	assert property (done_r && res_r.grp == CGD_G_MARK
		|-> tot_r == ((res_r.mem_we && ins_r.iw[8:0] != 9'h000) ? CGD_CYC_3 : CGD_CYC_2))
		else $error("jump-and-mark cycle count wrong");
	mark_return_a:
	assert property (done_r && res_r.grp == CGD_G_MARK && res_r.mem_we
		|-> res_r.next_p == res_r.mem_addr + 15'h0001 && res_r.mem_wdata == {1'b0, ins_r.p + 15'h0002})
		else $error("jump-and-mark return address wrong");
	exec_skip_a:
	assert property (done_r && res_r.grp == CGD_G_EXEC |-> tot_r == CGD_CYC_2 && res_r.next_p == ins_r.p + 15'h0002)
		else $error("execute did not continue past its address word");
	auto_cycles_a:
	assert property (done_r && res_r.grp == CGD_G_AUTO |-> tot_r == (jmp_r ? CGD_CYC_4 : CGD_CYC_3))
		else $error("auto-index cycle count wrong");
	auto_inc_a:
	assert property (st_r == S_IDX && idx_rvalid && kind_r == CGD_AUTO_INC_Z
		|=> res_r.mem_wdata == $past(idx_rdata) + 16'h0001 && jmp_r == (res_r.mem_wdata == 16'h0000))
		else $error("increment form wrote or tested the wrong value");
	auto_fetch_a:
	assert property ($rose(idx_rd_r) |-> idx_addr_r == ins_r.iw[4:0] && ins_r.iw[11:9] == CGD_M_AUX)
		else $error("index word fetched from the wrong location");
	io_input_a:
	assert property (done_r && io_r.valid && io_r.kind == CGD_IO_IN && io_r.sub == CGD_SUB_MEM |-> tot_r == CGD_CYC_3)
		else $error("input to memory did not take three cycles");
	ext_cycles_a:
	assert property (done_r && res_r.grp == CGD_G_EXT |-> tot_r == CGD_CYC_3)
		else $error("extended instruction did not take three cycles");
endmodule
`default_nettype wire
